// File: verilog/two_wire_slave_map.svh
// Register offsets, field positions, reset values and fixed figures of the two-wire slave.
// Included by the design files; holds definitions only.
`ifndef TWO_WIRE_SLAVE_MAP_SVH
`define TWO_WIRE_SLAVE_MAP_SVH

// Register offsets on the register port
`define OFS_BUS_CONTROL 8'hE8
`define OFS_BYTE_DATA 8'h9A
`define OFS_OWN_ADDRESS 8'h9B
`define OFS_SERIAL_PORT_CTRL 8'hF8
`define OFS_IRQ_ENABLE 8'hA9
`define OFS_GLOBAL_IRQ 8'hA8

// Field positions inside the bus control register
`define BIT_MASTER_SELECT 0
`define BIT_IFACE_RESET 1
`define BIT_DIRECTION 2
`define BIT_BYTE_DONE 3
`define BIT_HALTED 4

// Field positions inside the other control registers
`define BIT_PORT_SELECT 0
`define BIT_BUS_IRQ_EN 0
`define BIT_GLOBAL_IRQ_EN 7

// Reset values
`define RST_OWN_ADDRESS 8'h55
`define RST_BYTE_DATA 8'h00

// Core vector taken on every completed byte
`define BYTE_DONE_VECTOR 16'h003B

// Bits in one serial byte
`define BITS_PER_BYTE 4'h8

`endif

// File: verilog/two_wire_pkg.sv
// Types shared by the two-wire slave and its pin sampler.
// Assumes the constants header is included by the modules that need figures.
package two_wire_pkg;

  // Slave controller states
  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_ADDR     = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_STRETCH  = 4'h3,
    ST_RX       = 4'h4,
    ST_RX_ACK   = 4'h5,
    ST_TX       = 4'h6,
    ST_TX_ACK   = 4'h7,
    ST_HALT     = 4'h8
  } slave_state_e;

  // Sampled view of the two bus lines with their events
  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } bus_view_s;

endpackage : two_wire_pkg

// File: verilog/pin_sync.sv
// Pin sampler: brings both bus lines into the core clock and finds their events.
// Assumes the lines come from outside the clock domain and change slowly against clk.
`timescale 1ns/1ps
module pin_sync
  import two_wire_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Raw line levels
  input wire logic scl_pin_in,
  input wire logic sda_pin_in,
  // Sampled view
  output bus_view_s view
);

  logic [1:0] scl_meta_ff; // First stage is read only by the second
  logic [1:0] sda_meta_ff;
  logic scl_prev_ff; // Previous settled level for edge finding
  logic sda_prev_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Two flip-flops per line, then one more to compare against
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_meta_ff <= 2'h3;
      sda_meta_ff <= 2'h3;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_meta_ff <= {scl_meta_ff[0], scl_pin_in};
      sda_meta_ff <= {sda_meta_ff[0], sda_pin_in};
      scl_prev_ff <= scl_meta_ff[1];
      sda_prev_ff <= sda_meta_ff[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events from the settled stages only
  assign view.scl = scl_meta_ff[1];
  assign view.sda = sda_meta_ff[1];
  assign view.scl_rise = scl_meta_ff[1] & ~scl_prev_ff;
  assign view.scl_fall = ~scl_meta_ff[1] & scl_prev_ff;
  // Data edges count only while the clock line stays high on both samples
  assign view.start = scl_meta_ff[1] & scl_prev_ff & sda_prev_ff & ~sda_meta_ff[1];
  assign view.stop = scl_meta_ff[1] & scl_prev_ff & ~sda_prev_ff & sda_meta_ff[1];

endmodule : pin_sync

// File: verilog/two_wire_slave.sv
// Two-wire bus hardware slave with its software registers.
// Assumes a register port on clk and open-drain bus lines resolved outside.
// Summary of operation
// - Comes out of reset as hardware slave
// - Active only while port select bit clear
// - Master select bit clear selects slave
// - Own address register compared, software writable
// - All bytes pass through one data register
// - Idle slave waits for START
// - Flag set after START, match, direction
// - Interrupt needs flag, bus enable, global enable
// - Any data register access clears flag
// - Second access per event halts controller
// - Vector 003BH offered on each byte
// - First byte shows address and direction
// - Direction flag holds master's direction bit
// - Clock held low until flag cleared
// - Flag set after byte, ACK or NACK
// - Flag per byte until STOP or reset
// - STOP returns slave to idle, except from halt
// - NACK after sent byte returns idle
// - Interface reset bit forces idle, even halted
// - No status tells address from data event
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "two_wire_slave_map.svh"
module two_wire_slave
  import two_wire_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Serial clock line, open drain
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe,
  // Serial data line, open drain
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe,
  // Core interrupt
  output logic irq_req,
  output logic [15:0] irq_vector
);

  // Offsets are eight bits wide, a narrower port cannot reach them
  if (ADDR_W < 8) begin : g_bad_addr_w
    $error("two_wire_slave: ADDR_W must be at least 8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  bus_view_s view; // Sampled lines and events
  slave_state_e state_ff, nxt_state;
  logic [3:0] bitcnt_ff, nxt_bitcnt; // Bits moved in the current byte
  logic [7:0] shreg_ff, nxt_shreg; // Serial shift register
  logic sda_oe_ff, nxt_sda_oe; // Pull data line low
  logic scl_oe_ff, nxt_scl_oe; // Pull clock line low
  logic nack_ff, nxt_nack; // Master answer to a sent byte
  logic flag_set; // Byte finished this cycle
  logic data_load; // Copy received byte into data register
  logic dir_load; // Capture direction bit
  // Software registers
  logic port_select_ff; // Shared pins given to the other port
  logic master_select_ff; // Software master instead of slave
  logic [7:0] own_addr_ff;
  logic [7:0] data_ff;
  logic dir_ff;
  logic flag_ff;
  logic access_used_ff; // Data register already touched for this event
  logic bus_irq_en_ff;
  logic global_irq_en_ff;
  logic [7:0] rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling
  pin_sync u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .scl_pin_in(serial_clock_pin_in),
    .sda_pin_in(serial_data_pin_in),
    .view(view)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register decode
  wire [7:0] addr8 = reg_addr[7:0];
  wire hi_zero = (reg_addr >> 8) == '0;
  wire sel_ctrl = hi_zero & (addr8 == `OFS_BUS_CONTROL);
  wire sel_data = hi_zero & (addr8 == `OFS_BYTE_DATA);
  wire sel_own = hi_zero & (addr8 == `OFS_OWN_ADDRESS);
  wire sel_port = hi_zero & (addr8 == `OFS_SERIAL_PORT_CTRL);
  wire sel_irqen = hi_zero & (addr8 == `OFS_IRQ_ENABLE);
  wire sel_gie = hi_zero & (addr8 == `OFS_GLOBAL_IRQ);
  // A read or a write of the data register counts as one access
  wire data_access = sel_data & (reg_wr | reg_rd);
  wire data_write = sel_data & reg_wr;
  // Reset bit is a write-one pulse, it never stores
  wire iface_reset = sel_ctrl & reg_wr & reg_wdata[`BIT_IFACE_RESET];
  // Slave runs only with the pins ours and master mode off
  wire slave_active = ~port_select_ff & ~master_select_ff;
  // A second access with no new event in between stops the controller
  wire double_access = data_access & access_used_ff & ~flag_ff;
  // Seven-bit address sits above the direction bit
  wire addr_match = shreg_ff[7:1] == own_addr_ff[6:0];
  wire byte_full = bitcnt_ff == `BITS_PER_BYTE;
  wire halted = state_ff == ST_HALT;
  // Address and data events look the same: only flag and direction are shown
  wire [7:0] ctrl_word = {3'h0, halted, flag_ff, dir_ff, 1'b0, master_select_ff};
  wire [7:0] rd_word = sel_ctrl ? ctrl_word :
                       sel_data ? data_ff :
                       sel_own ? own_addr_ff :
                       sel_port ? {7'h00, port_select_ff} :
                       sel_irqen ? {7'h00, bus_irq_en_ff} :
                       sel_gie ? {global_irq_en_ff, 7'h00} : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Slave sequencer next state
  always_comb begin
    nxt_state = state_ff;
    nxt_bitcnt = bitcnt_ff;
    nxt_shreg = shreg_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_scl_oe = scl_oe_ff;
    nxt_nack = nack_ff;
    flag_set = 1'b0;
    data_load = 1'b0;
    dir_load = 1'b0;
    if (!slave_active || iface_reset) begin
      // Forced idle, lines let go, even from halt
      nxt_state = ST_IDLE;
      nxt_sda_oe = 1'b0;
      nxt_scl_oe = 1'b0;
    end else if (halted) begin
      // Halt holds until the reset bit is written or the slave is shut out
      nxt_state = ST_HALT;
    end else if (double_access) begin
      // Lines released so a stuck controller cannot lock the bus
      nxt_state = ST_HALT;
      nxt_sda_oe = 1'b0;
      nxt_scl_oe = 1'b0;
    end else if (view.stop) begin
      nxt_state = ST_IDLE;
      nxt_sda_oe = 1'b0;
      nxt_scl_oe = 1'b0;
    end else if (view.start) begin
      // Also taken as repeated START from any state but halt
      nxt_state = ST_ADDR;
      nxt_bitcnt = 4'h0;
      nxt_sda_oe = 1'b0;
      nxt_scl_oe = 1'b0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          // Traffic ignored until a START
          nxt_state = ST_IDLE;
        end
        ST_ADDR, ST_RX: begin
          // Sample on rising clock, decide after the eighth falling one
          if (view.scl_rise && !byte_full) begin
            nxt_shreg = {shreg_ff[6:0], view.sda};
            nxt_bitcnt = bitcnt_ff + 4'h1;
          end
          if (view.scl_fall && byte_full) begin
            nxt_bitcnt = 4'h0;
            if (state_ff == ST_RX) begin
              nxt_state = ST_RX_ACK;
              nxt_sda_oe = 1'b1;
            end else if (addr_match) begin
              nxt_state = ST_ADDR_ACK;
              nxt_sda_oe = 1'b1;
            end else begin
              // Another slave's address: stay off the bus
              nxt_state = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK, ST_RX_ACK: begin
          // ACK held through the ninth clock, then stretch
          if (view.scl_fall) begin
            nxt_sda_oe = 1'b0;
            nxt_scl_oe = 1'b1;
            flag_set = 1'b1;
            data_load = 1'b1;
            dir_load = state_ff == ST_ADDR_ACK;
            nxt_state = ST_STRETCH;
          end
        end
        ST_STRETCH: begin
          // Clock released only once software has cleared the flag
          if (!flag_ff) begin
            nxt_scl_oe = 1'b0;
            nxt_bitcnt = 4'h0;
            if (dir_ff) begin
              // First bit put out in the same cycle the clock is let go
              nxt_state = ST_TX;
              nxt_shreg = data_ff;
              nxt_sda_oe = ~data_ff[7];
              nxt_bitcnt = 4'h1;
            end else begin
              nxt_state = ST_RX;
            end
          end
        end
        ST_TX: begin
          // Next bit goes out on each falling clock
          if (view.scl_fall) begin
            if (byte_full) begin
              nxt_sda_oe = 1'b0;
              nxt_state = ST_TX_ACK;
            end else begin
              nxt_shreg = {shreg_ff[6:0], 1'b0};
              nxt_sda_oe = ~shreg_ff[6];
              nxt_bitcnt = bitcnt_ff + 4'h1;
            end
          end
        end
        ST_TX_ACK: begin
          // Master answer sampled on the ninth rising clock
          if (view.scl_rise) begin
            nxt_nack = view.sda;
          end
          if (view.scl_fall) begin
            flag_set = 1'b1;
            if (nack_ff) begin
              nxt_state = ST_IDLE;
            end else begin
              nxt_scl_oe = 1'b1;
              nxt_state = ST_STRETCH;
            end
          end
        end
        ST_HALT: begin
          nxt_state = ST_HALT;
        end
        default: begin
          // Unused codes fall back to idle
          nxt_state = ST_IDLE;
          nxt_sda_oe = 1'b0;
          nxt_scl_oe = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      bitcnt_ff <= 4'h0;
      shreg_ff <= 8'h00;
      sda_oe_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
      nack_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      bitcnt_ff <= nxt_bitcnt;
      shreg_ff <= nxt_shreg;
      sda_oe_ff <= nxt_sda_oe;
      scl_oe_ff <= nxt_scl_oe;
      nack_ff <= nxt_nack;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers; reset values give slave mode with no setup
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port_select_ff <= 1'b0;
      master_select_ff <= 1'b0;
      own_addr_ff <= `RST_OWN_ADDRESS;
      bus_irq_en_ff <= 1'b0;
      global_irq_en_ff <= 1'b0;
    end else if (reg_wr) begin
      if (sel_port) port_select_ff <= reg_wdata[`BIT_PORT_SELECT];
      if (sel_ctrl) master_select_ff <= reg_wdata[`BIT_MASTER_SELECT];
      if (sel_own) own_addr_ff <= reg_wdata;
      if (sel_irqen) bus_irq_en_ff <= reg_wdata[`BIT_BUS_IRQ_EN];
      if (sel_gie) global_irq_en_ff <= reg_wdata[`BIT_GLOBAL_IRQ_EN];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data register: a finished byte wins over a software write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_ff <= `RST_BYTE_DATA;
    end else if (data_load) begin
      data_ff <= shreg_ff;
    end else if (data_write) begin
      data_ff <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Direction and byte flag; a new event beats a clearing access
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dir_ff <= 1'b0;
      flag_ff <= 1'b0;
    end else begin
      if (dir_load) dir_ff <= shreg_ff[0];
      if (flag_set) begin
        flag_ff <= 1'b1;
      end else if (data_access || iface_reset || !slave_active) begin
        flag_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One access allowed per flag event
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      access_used_ff <= 1'b0;
    end else if (flag_set || iface_reset) begin
      access_used_ff <= 1'b0;
    end else if (data_access) begin
      access_used_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= reg_rd ? rd_word : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata = rdata_ff;
  // Open drain: the lines are only ever pulled low
  assign serial_clock_pin_out = 1'b0;
  assign serial_clock_pin_oe = scl_oe_ff;
  assign serial_data_pin_out = 1'b0;
  assign serial_data_pin_oe = sda_oe_ff;
  // Both enables must be on for the core to see the byte event
  assign irq_req = flag_ff & bus_irq_en_ff & global_irq_en_ff;
  assign irq_vector = `BYTE_DONE_VECTOR;

endmodule : two_wire_slave

// File: tb/two_wire_slave_properties.sv
// Checker for the two-wire slave: port timing relations.
// Assumes it is bound to every two_wire_slave instance.
`timescale 1ns/1ps
`include "two_wire_slave_map.svh"
module two_wire_slave_checker #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Bus lines
  input wire logic serial_clock_pin_in,
  input wire logic serial_clock_pin_out,
  input wire logic serial_clock_pin_oe,
  input wire logic serial_data_pin_out,
  input wire logic serial_data_pin_oe,
  // Interrupt
  input wire logic irq_req,
  input wire logic [15:0] irq_vector
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // Data register access, and a cycle with no access or write
  wire data_acc = (reg_wr || reg_rd) && reg_addr == `OFS_BYTE_DATA;
  wire quiet = !data_acc && !reg_wr;
  wire mask_wr = reg_wr && (reg_addr == `OFS_GLOBAL_IRQ && !reg_wdata[`BIT_GLOBAL_IRQ_EN]
    || reg_addr == `OFS_IRQ_ENABLE && !reg_wdata[`BIT_BUS_IRQ_EN]);
  wire off_wr = reg_wr && reg_wdata[0] && (reg_addr == `OFS_SERIAL_PORT_CTRL || reg_addr == `OFS_BUS_CONTROL);
  wire rst_wr = reg_wr && reg_addr == `OFS_BUS_CONTROL && reg_wdata[`BIT_IFACE_RESET];
  property p_vector; irq_vector == `BYTE_DONE_VECTOR; endproperty
  a_vector: assert property (p_vector) else $error("vector changed");
  property p_open_drain; !serial_clock_pin_out && !serial_data_pin_out; endproperty
  a_open_drain: assert property (p_open_drain) else $error("line driven high");
  property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
  property p_irq_mask; mask_wr |=> !irq_req; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq while disabled");
  property p_release; serial_clock_pin_oe && data_acc |-> ##[1:3] !serial_clock_pin_oe; endproperty
  a_release: assert property (p_release) else $error("clock not released");
  property p_hold; serial_clock_pin_oe && quiet && $past(quiet) && $past(quiet, 2) |=> serial_clock_pin_oe; endproperty
  a_hold: assert property (p_hold) else $error("stretch ended early");
  property p_stretch_data; serial_clock_pin_oe |-> !serial_data_pin_oe; endproperty
  a_stretch_data: assert property (p_stretch_data) else $error("data held in stretch");
  property p_iface_reset; rst_wr |-> ##2 (!serial_clock_pin_oe && !serial_data_pin_oe) [*4]; endproperty
  a_iface_reset: assert property (p_iface_reset) else $error("reset left lines held");
  property p_disable; off_wr |=> ##[0:2] (!serial_clock_pin_oe && !serial_data_pin_oe); endproperty
  a_disable: assert property (p_disable) else $error("disabled slave drives");
  c_stretch: cover property ($rose(serial_clock_pin_oe));
  c_irq: cover property ($rose(irq_req));
  c_ack: cover property ($rose(serial_data_pin_oe));
endmodule : two_wire_slave_checker

bind two_wire_slave two_wire_slave_checker #(.ADDR_W(ADDR_W)) u_chk (.*);

// File: tb/two_wire_master_model.sv
// Behavioural bus master that clocks the slave's serial lines.
// Assumes open-drain lines resolved with pull-ups by the bench.
`timescale 1ns/1ps
module two_wire_master_model (
  // Resolved line levels
  input wire logic scl,
  input wire logic sda,
  // High pulls the line low
  output logic scl_low,
  output logic sda_low
);
  int hangs = 0; // Stretch waits that ran out
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  ////////////////////////////////////////
  // Release clock, wait out a stretch, sample data mid-high
  task automatic clk_high(output logic r);
    int n;
    n = 0;
    scl_low = 1'b0;
    while (scl !== 1'b1 && n < 400) begin
      #25;
      n++;
    end
    if (n == 400) hangs++;
    #75 r = sda;
    #75;
  endtask : clk_high
  // Data only moves while the clock is low, so no false START
  task automatic put_bit(input logic b, output logic r);
    // Clock pulled low first, so a bus left idle after STOP sees no false START
    scl_low = 1'b1;
    #25;
    sda_low = ~b;
    #100;
    clk_high(r);
    scl_low = 1'b1;
    #125;
  endtask : put_bit
  task automatic put_byte(input logic [7:0] d, input logic ack_b, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], r);
      q = {q[6:0], r};
    end
    put_bit(ack_b, ack);
  endtask : put_byte
  task automatic start_cond();
    logic r;
    sda_low = 1'b0;
    #125;
    clk_high(r);
    sda_low = 1'b1;
    #75;
    scl_low = 1'b1;
    #125;
  endtask : start_cond
  task automatic stop_cond();
    logic r;
    sda_low = 1'b1;
    #125;
    clk_high(r);
    sda_low = 1'b0;
    #400;
  endtask : stop_cond
endmodule : two_wire_master_model

// File: tb/tb_top.sv
// Self-checking bench for the two-wire slave.
// Assumes the master model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`include "two_wire_slave_map.svh"
module tb_top;
  typedef struct packed { logic [7:0] addr; logic wr; logic [7:0] wd; logic [7:0] exp; } row_s;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata, q, rd;
  logic scl_oe, sda_oe, irq_req, ack;
  logic [15:0] irq_vector;
  wire scl_w, sda_w, m_scl_low, m_sda_low;
  int bad_count = 0;
  int checks = 0;
  // Register rows: optional write, then read back
  row_s rows [7] = '{
    '{`OFS_OWN_ADDRESS, 1'b0, 8'h00, `RST_OWN_ADDRESS},
    '{`OFS_BUS_CONTROL, 1'b0, 8'h00, 8'h00},
    '{`OFS_SERIAL_PORT_CTRL, 1'b0, 8'h00, 8'h00},
    '{`OFS_IRQ_ENABLE, 1'b1, 8'hff, 8'h01},
    '{`OFS_GLOBAL_IRQ, 1'b1, 8'hff, 8'h80},
    '{8'h10, 1'b1, 8'hff, 8'h00},
    '{`OFS_OWN_ADDRESS, 1'b1, 8'h22, 8'h22}};
  always #25 clk = ~clk;
  // Wired-AND lines with pull-ups
  assign scl_w = ~(scl_oe | m_scl_low);
  assign sda_w = ~(sda_oe | m_sda_low);
  two_wire_slave #(.ADDR_W(8)) u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_clock_pin_in(scl_w),
    .serial_clock_pin_out(), .serial_clock_pin_oe(scl_oe), .serial_data_pin_in(sda_w),
    .serial_data_pin_out(), .serial_data_pin_oe(sda_oe), .irq_req(irq_req), .irq_vector(irq_vector));
  two_wire_master_model u_master (.scl(scl_w), .sda(sda_w), .scl_low(m_scl_low), .sda_low(m_sda_low));
  ////////////////////////////////////////
  task automatic final_report();
    if (bad_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Strobes last one cycle; tasks return at a falling edge
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(negedge clk);
  endtask : reg_write
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : reg_read
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    reg_read(a, rd);
    chk($sformatf("reg %h", a), e, rd);
  endtask : rd_chk
  task automatic addr_phase(input logic [7:0] a);
    u_master.start_cond();
    u_master.put_byte(a, 1'b1, q, ack);
  endtask : addr_phase
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (rows[i]) begin
      if (rows[i].wr) reg_write(rows[i].addr, rows[i].wd);
      rd_chk(rows[i].addr, rows[i].exp);
    end
    // Foreign address gets no answer
    addr_phase(8'haa);
    chk("foreign ack", 8'h01, {7'h00, ack});
    rd_chk(`OFS_BUS_CONTROL, 8'h00);
    u_master.stop_cond();
    // Port select, then master select, shut the slave out
    for (int k = 0; k < 2; k++) begin
      reg_write(k ? `OFS_BUS_CONTROL : `OFS_SERIAL_PORT_CTRL, 8'h01);
      addr_phase(8'h44);
      chk("off ack", 8'h01, {7'h00, ack});
      reg_write(k ? `OFS_BUS_CONTROL : `OFS_SERIAL_PORT_CTRL, 8'h00);
      u_master.stop_cond();
    end
    // Master writes one byte
    addr_phase(8'h44);
    chk("addr ack", 8'h00, {7'h00, ack});
    repeat (10) @(negedge clk);
    chk("stretch", 8'h01, {7'h00, scl_oe});
    chk("irq", 8'h01, {7'h00, irq_req});
    reg_write(`OFS_GLOBAL_IRQ, 8'h00);
    chk("irq masked", 8'h00, {7'h00, irq_req});
    reg_write(`OFS_GLOBAL_IRQ, 8'h80);
    chk("irq back", 8'h01, {7'h00, irq_req});
    reg_write(`OFS_IRQ_ENABLE, 8'h00);
    chk("irq bus masked", 8'h00, {7'h00, irq_req});
    reg_write(`OFS_IRQ_ENABLE, 8'h01);
    chk("irq vector", 8'h01, {7'h00, irq_vector === `BYTE_DONE_VECTOR});
    rd_chk(`OFS_BUS_CONTROL, 8'h08);
    rd_chk(`OFS_BYTE_DATA, 8'h44);
    chk("irq cleared", 8'h00, {7'h00, irq_req});
    u_master.put_byte(8'h3c, 1'b1, q, ack);
    chk("data ack", 8'h00, {7'h00, ack});
    rd_chk(`OFS_BUS_CONTROL, 8'h08);
    rd_chk(`OFS_BYTE_DATA, 8'h3c);
    u_master.stop_cond();
    u_master.put_byte(8'h44, 1'b1, q, ack);
    chk("idle ack", 8'h01, {7'h00, ack});
    // Master reads one byte and ends with NACK
    addr_phase(8'h45);
    rd_chk(`OFS_BUS_CONTROL, 8'h0c);
    reg_write(`OFS_BYTE_DATA, 8'ha5);
    u_master.put_byte(8'hff, 1'b1, q, ack);
    chk("sent byte", 8'ha5, q);
    repeat (10) @(negedge clk);
    chk("no stretch", 8'h00, {7'h00, scl_oe});
    rd_chk(`OFS_BUS_CONTROL, 8'h0c);
    reg_read(`OFS_BYTE_DATA, rd);
    u_master.stop_cond();
    // Double access halts; interface reset recovers
    addr_phase(8'h44);
    rd_chk(`OFS_BYTE_DATA, 8'h44);
    reg_read(`OFS_BYTE_DATA, rd);
    rd_chk(`OFS_BUS_CONTROL, 8'h10);
    reg_write(`OFS_BUS_CONTROL, 8'h02);
    rd_chk(`OFS_BUS_CONTROL, 8'h00);
    u_master.stop_cond();
    // Reset in mid-transfer
    addr_phase(8'h44);
    chk("ack after halt", 8'h00, {7'h00, ack});
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(negedge clk);
    chk("reset stretch", 8'h00, {7'h00, scl_oe});
    @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(`OFS_OWN_ADDRESS, `RST_OWN_ADDRESS);
    u_master.stop_cond();
    chk("stretch waits", 8'h00, {7'h00, u_master.hangs != 0});
    final_report();
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    $display("[FAIL] run end expected done seen timeout");
    final_report();
  end
endmodule : tb_top
